//--- hdl/fcd_top.sv
/*
  Command interpreter of a 32-bit parallel flash: turns sequences of host
  bus writes into read-mode changes and operation requests, holds the
  status and burst setup words, and answers host reads.
  Assumes the program/erase engine, array, query table and protection
  storage sit outside and react to the issued operations.
*/
`timescale 1ns/1ps
module fcd_top
  import fcd_pkg::*;
#(
  parameter logic [DATA_W-1:0] MAKER_CODE = 32'h000000a5, // Arbitrary value.
  parameter logic [DATA_W-1:0] PART_CODE = 32'h00001234, // Arbitrary value.
  parameter int BLK_OFS_W = 14
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire fcd_wr_t HOST_WR_I,
  input wire logic RD_STB_I,
  input wire logic [ADDR_W-1:0] READ_LOCATION_I,
  input wire logic [DATA_W-1:0] ARRAY_DATA_I,
  input wire logic [DATA_W-1:0] QUERY_DATA_I,
  input wire logic PROT_STATE_I,
  input wire logic PEC_BUSY_I,
  input wire logic [7:0] STS_SET_I,
  output fcd_op_t OP_O,
  output logic [DATA_W-1:0] RD_DATA_O,
  output logic RD_VALID_O,
  output fcd_mode_t READ_MODE_O,
  output logic [BURST_W-1:0] BURST_SETUP_WORD_O,
  output logic [7:0] STATUS_VALUE_O
);

  fcd_state_t state, next_state;
  fcd_mode_t mode, next_mode;
  fcd_op_t op, next_op;
  logic [BURST_W-1:0] burst, next_burst;
  logic [7:0] sts, next_sts;
  logic [BUF_CNT_W-1:0] left, next_left;
  logic susp, next_susp;
  logic all_run, next_all_run;
  logic otp_ok, next_otp_ok;
  logic seq_err, clr_sts;
  logic [7:0] cmd;
  logic [ADDR_W-1:0] wa;

  assign cmd = HOST_WR_I.data[7:0];
  assign wa = HOST_WR_I.addr;

  // Command sequencer. Only the low data byte is compared where the code
  // is a byte, and the address is looked at only on cycles that need it.
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_op = '0;
    next_burst = burst;
    next_left = left;
    next_susp = susp;
    next_all_run = all_run;
    next_otp_ok = otp_ok;
    seq_err = 1'b0;
    clr_sts = 1'b0;
    if (HOST_WR_I.stb) begin
      if (PEC_BUSY_I) begin
        // The engine is working: anything else is dropped silently.
        if (cmd == CMD_STATUS) begin
          next_mode = RM_STATUS;
        end else if (cmd == CMD_SUSPEND && !all_run) begin
          next_op = '{valid: 1'b1, kind: OP_SUSPEND, otp_ok: 1'b0, addr: wa,
                      data: HOST_WR_I.data};
          next_susp = 1'b1;
        end
      end else begin
        unique case (state)
          ST_IDLE: begin
            // Single-cycle commands ignore the address lines.
            if (cmd == CMD_READ_ARRAY) begin
              next_mode = RM_ARRAY;
            end else if (cmd == CMD_READ_ID) begin
              next_mode = RM_IDENT;
            end else if (cmd == CMD_QUERY) begin
              next_mode = RM_QUERY;
            end else if (cmd == CMD_STATUS) begin
              next_mode = RM_STATUS;
            end else if (cmd == CMD_CLR_STS) begin
              clr_sts = 1'b1;
            end else if (cmd == CMD_CONFIRM && susp) begin
              next_op = '{valid: 1'b1, kind: OP_RESUME, otp_ok: 1'b0, addr: wa,
                          data: HOST_WR_I.data};
              next_susp = 1'b0;
              next_mode = RM_STATUS;
            end else if (cmd == CMD_CFG) begin
              next_state = ST_CFG;
            end else if (cmd == CMD_BLK_ERASE && wa == ADR_UNLOCK_A) begin
              next_state = ST_ERS;
            end else if (cmd == CMD_ALL_ERASE && wa == ADR_UNLOCK_A) begin
              next_state = ST_ALL;
            end else if ((cmd == CMD_PGM || cmd == CMD_PGM_ALT) && wa == ADR_UNLOCK_B) begin
              next_state = ST_PGM;
              next_otp_ok = (cmd == CMD_PGM);
            end else if (cmd == CMD_BUF_PGM && wa == ADR_UNLOCK_B) begin
              next_state = ST_BUF_CNT;
              next_mode = RM_STATUS;
            end else if (cmd == CMD_OTP && wa == ADR_UNLOCK_B) begin
              next_state = ST_OTP;
            end
          end
          ST_ERS, ST_ALL: begin
            next_state = ST_IDLE;
            next_mode = RM_STATUS;
            if (cmd == CMD_CONFIRM && (state == ST_ERS || wa == ADR_UNLOCK_B)) begin
              next_op = '{valid: 1'b1, kind: (state == ST_ERS) ? OP_BLK_ERASE : OP_ALL_ERASE,
                          otp_ok: 1'b0, addr: wa, data: HOST_WR_I.data};
              next_all_run = (state == ST_ALL);
            end else begin
              seq_err = 1'b1;
            end
          end
          ST_PGM: begin
            next_state = ST_IDLE;
            // An all-ones word after the setup cancels the program.
            if (HOST_WR_I.data != PGM_ABORT_WORD) begin
              next_op = '{valid: 1'b1, kind: OP_PROGRAM, otp_ok: otp_ok, addr: wa,
                          data: HOST_WR_I.data};
              next_all_run = 1'b0;
              next_mode = RM_STATUS;
            end
          end
          ST_BUF_CNT: begin
            // Count values of eight or more, nine words or more, cannot fit the write buffer.
            if (HOST_WR_I.data[DATA_W-1:BUF_CNT_W] == '0) begin
              next_op = '{valid: 1'b1, kind: OP_BUF_START, otp_ok: 1'b0, addr: wa,
                          data: HOST_WR_I.data};
              next_left = HOST_WR_I.data[BUF_CNT_W-1:0];
              next_state = ST_BUF_LOAD;
            end else begin
              seq_err = 1'b1;
              next_state = ST_IDLE;
            end
          end
          ST_BUF_LOAD: begin
            next_op = '{valid: 1'b1, kind: OP_BUF_WORD, otp_ok: 1'b0, addr: wa,
                        data: HOST_WR_I.data};
            if (left == '0) begin
              next_state = ST_BUF_CONF;
            end else begin
              next_left = left - 1'b1;
            end
          end
          ST_BUF_CONF: begin
            next_state = ST_IDLE;
            if (cmd == CMD_CONFIRM) begin
              next_op = '{valid: 1'b1, kind: OP_BUF_COMMIT, otp_ok: 1'b0, addr: wa,
                          data: HOST_WR_I.data};
              next_all_run = 1'b0;
            end else begin
              seq_err = 1'b1;
            end
          end
          ST_CFG: begin
            next_state = ST_IDLE;
            if (cmd == CMD_CFG_BURST) begin
              next_burst = wa[BURST_W-1:0];
            end else if (cmd == CMD_PROT_SET || cmd == CMD_CONFIRM) begin
              next_op = '{valid: 1'b1, kind: (cmd == CMD_PROT_SET) ? OP_PROT_SET : OP_PROT_CLR,
                          otp_ok: 1'b0, addr: wa, data: HOST_WR_I.data};
            end else begin
              seq_err = 1'b1;
            end
          end
          ST_OTP: begin
            next_state = ST_IDLE;
            if (cmd == CMD_OTP_LOCK && wa == ADR_OTP_LOCK) begin
              next_op = '{valid: 1'b1, kind: OP_OTP_LOCK, otp_ok: 1'b1, addr: wa,
                          data: HOST_WR_I.data};
            end else begin
              seq_err = 1'b1;
            end
          end
          default: next_state = ST_IDLE;
        endcase
      end
    end
  end

  // Status word: engine events and sequence errors win over a clear.
  always_comb begin
    next_sts = (sts & ~(clr_sts ? STS_CLR_MASK : 8'h00)) | STS_SET_I
               | (seq_err ? STS_SEQ_ERR : 8'h00);
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
      mode <= RM_ARRAY;
      op <= '0;
      burst <= BURST_RESET;
      sts <= STS_RESET;
      left <= '0;
      susp <= 1'b0;
      all_run <= 1'b0;
      otp_ok <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      op <= next_op;
      burst <= next_burst;
      sts <= next_sts;
      left <= next_left;
      susp <= next_susp;
      all_run <= next_all_run;
      otp_ok <= next_otp_ok;
    end
  end

  assign OP_O = op;
  assign READ_MODE_O = mode;
  assign BURST_SETUP_WORD_O = burst;
  // The ready bit is live from the engine, the rest is the sticky word.
  assign STATUS_VALUE_O = {~PEC_BUSY_I, sts[STS_READY_BIT-1:0]};

  fcd_read_port #(
    .MAKER_CODE(MAKER_CODE),
    .PART_CODE(PART_CODE),
    .BLK_OFS_W(BLK_OFS_W)
  ) u_read (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .rd_stb_i(RD_STB_I),
    .rd_addr_i(READ_LOCATION_I),
    .mode_i(mode),
    .array_data_i(ARRAY_DATA_I),
    .query_data_i(QUERY_DATA_I),
    .status_i(STATUS_VALUE_O),
    .burst_i(burst),
    .prot_i(PROT_STATE_I),
    .rd_data_o(RD_DATA_O),
    .rd_valid_o(RD_VALID_O)
  );

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  logic idle_wr;
  assign idle_wr = HOST_WR_I.stb && !PEC_BUSY_I && state == ST_IDLE;

  sequence s_ers_setup;
    idle_wr && cmd == CMD_BLK_ERASE && wa == ADR_UNLOCK_A;
  endsequence
  // The confirm may come after idle bus cycles, so it is tied to the setup state.
  sequence s_ers_confirm;
    state == ST_ERS && HOST_WR_I.stb && !PEC_BUSY_I && cmd == CMD_CONFIRM;
  endsequence

  a_array_enter: assert property (idle_wr && cmd == CMD_READ_ARRAY |=> mode == RM_ARRAY)
    else $error("array mode not entered");
  a_array_hold: assert property (mode == RM_ARRAY && !HOST_WR_I.stb |=> mode == RM_ARRAY)
    else $error("array mode left without a write");
  a_ident_enter: assert property (idle_wr && cmd == CMD_READ_ID |=> mode == RM_IDENT)
    else $error("identifier mode not entered");
  a_query_enter: assert property (idle_wr && cmd == CMD_QUERY |=> mode == RM_QUERY)
    else $error("query mode not entered");
  a_status_read: assert property (mode == RM_STATUS && RD_STB_I
                                  |=> RD_VALID_O && RD_DATA_O[7:0] == $past(STATUS_VALUE_O))
    else $error("status read returned wrong data");
  a_erase_issue: assert property (s_ers_setup ##[1:8] s_ers_confirm
                                  |=> OP_O.valid && OP_O.kind == OP_BLK_ERASE
                                      && OP_O.addr == $past(wa) && mode == RM_STATUS)
    else $error("block erase not issued");
  a_status_clear: assert property (idle_wr && cmd == CMD_CLR_STS && STS_SET_I == 8'h00
                                   |=> (sts & STS_CLR_MASK) == 8'h00 && $stable(mode))
    else $error("status clear failed");
  a_busy_ignore: assert property (HOST_WR_I.stb && PEC_BUSY_I && cmd != CMD_STATUS
                                  |=> $stable(mode) && $stable(state)
                                      && (!OP_O.valid || OP_O.kind == OP_SUSPEND))
    else $error("command accepted while busy");
  a_burst_load: assert property (state == ST_CFG && HOST_WR_I.stb && !PEC_BUSY_I
                                 && cmd == CMD_CFG_BURST
                                 |=> burst == $past(wa[BURST_W-1:0]) && state == ST_IDLE)
    else $error("burst word not loaded");

endmodule

//--- hdl/fcd_pkg.sv
/*
  Shared constants and types of the flash command decoder: command codes,
  fixed command addresses, identifier offsets, status masks and the packed
  carriers for host writes and issued operations.
  Assumes a 32-bit data bus and a word address of ADDR_W bits.
*/
package fcd_pkg;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 32;
  localparam int BURST_W = 16;
  localparam int BUF_CNT_W = 3;

  // Command codes, taken from the low data byte of a bus write.
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STS = 8'h50;
  localparam logic [7:0] CMD_BLK_ERASE = 8'h20;
  localparam logic [7:0] CMD_ALL_ERASE = 8'h80;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_PGM = 8'h40;
  localparam logic [7:0] CMD_PGM_ALT = 8'h10;
  localparam logic [7:0] CMD_BUF_PGM = 8'he8;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_CFG = 8'h60;
  localparam logic [7:0] CMD_CFG_BURST = 8'h03;
  localparam logic [7:0] CMD_PROT_SET = 8'h01;
  localparam logic [7:0] CMD_OTP = 8'h49;
  localparam logic [7:0] CMD_OTP_LOCK = 8'h00;
  localparam logic [DATA_W-1:0] PGM_ABORT_WORD = 32'hffffffff;

  // Fixed addresses of the unlock cycles and the OTP lock cycle.
  localparam logic [ADDR_W-1:0] ADR_UNLOCK_A = 21'h00055;
  localparam logic [ADDR_W-1:0] ADR_UNLOCK_B = 21'h000aa;
  localparam logic [ADDR_W-1:0] ADR_OTP_LOCK = 21'h00003;

  // Identifier mode offsets.
  localparam logic [ADDR_W-1:0] ID_MAKER_ADR = 21'h00000;
  localparam logic [ADDR_W-1:0] ID_PART_ADR = 21'h00001;
  localparam logic [ADDR_W-1:0] ID_BURST_ADR = 21'h00005;
  localparam logic [ADDR_W-1:0] ID_PROT_OFS = 21'h00002;

  // Status register layout and reset values.
  localparam logic [7:0] STS_CLR_MASK = 8'h3a;
  localparam logic [7:0] STS_SEQ_ERR = 8'h30;
  localparam logic [7:0] STS_RESET = 8'h00;
  localparam int STS_READY_BIT = 7;
  localparam logic [BURST_W-1:0] BURST_RESET = 16'h0000;

  typedef enum logic [3:0] {
    RM_ARRAY = 4'b0001,
    RM_IDENT = 4'b0010,
    RM_QUERY = 4'b0100,
    RM_STATUS = 4'b1000
  } fcd_mode_t;

  typedef enum logic [9:0] {
    ST_IDLE = 10'b0000000001,
    ST_ERS = 10'b0000000010,
    ST_ALL = 10'b0000000100,
    ST_PGM = 10'b0000001000,
    ST_BUF_CNT = 10'b0000010000,
    ST_BUF_LOAD = 10'b0000100000,
    ST_BUF_CONF = 10'b0001000000,
    ST_CFG = 10'b0010000000,
    ST_OTP = 10'b0100000000,
    ST_SPARE = 10'b1000000000
  } fcd_state_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_BLK_ERASE = 4'h1,
    OP_ALL_ERASE = 4'h2,
    OP_PROGRAM = 4'h3,
    OP_BUF_START = 4'h4,
    OP_BUF_WORD = 4'h5,
    OP_BUF_COMMIT = 4'h6,
    OP_SUSPEND = 4'h7,
    OP_RESUME = 4'h8,
    OP_PROT_SET = 4'h9,
    OP_PROT_CLR = 4'ha,
    OP_OTP_LOCK = 4'hb
  } fcd_op_kind_t;

  typedef struct packed {
    logic stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcd_wr_t;

  typedef struct packed {
    logic valid;
    fcd_op_kind_t kind;
    logic otp_ok;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcd_op_t;

endpackage

//--- hdl/fcd_read_port.sv
/*
  Read return path of the flash command decoder: picks array, identifier,
  query or status data by read mode and registers it.
  Assumes array and query data arrive combinationally for the read address.
*/
`timescale 1ns/1ps
module fcd_read_port
  import fcd_pkg::*;
#(
  parameter logic [DATA_W-1:0] MAKER_CODE = 32'h000000a5, // Arbitrary value.
  parameter logic [DATA_W-1:0] PART_CODE = 32'h00001234, // Arbitrary value.
  parameter int BLK_OFS_W = 14
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rd_stb_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  input wire fcd_mode_t mode_i,
  input wire logic [DATA_W-1:0] array_data_i,
  input wire logic [DATA_W-1:0] query_data_i,
  input wire logic [7:0] status_i,
  input wire logic [BURST_W-1:0] burst_i,
  input wire logic prot_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic rd_valid_o
);

  logic [DATA_W-1:0] next_rd_data;

  // Identifier words; offsets 0, 1 and 5 win over the block-relative offset.
  function automatic logic [DATA_W-1:0] id_word(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w;
    w = '0;
    if (a == ID_MAKER_ADR) begin
      w = MAKER_CODE;
    end else if (a == ID_PART_ADR) begin
      w = PART_CODE;
    end else if (a == ID_BURST_ADR) begin
      w = {{(DATA_W-BURST_W){1'b0}}, burst_i};
    end else if (a[BLK_OFS_W-1:0] == ID_PROT_OFS[BLK_OFS_W-1:0]) begin
      w = {{(DATA_W-1){1'b0}}, prot_i};
    end
    return w;
  endfunction

  // Data selection by the current read mode; the mode holds between writes.
  always_comb begin
    next_rd_data = rd_data_o;
    if (rd_stb_i) begin
      unique case (mode_i)
        RM_ARRAY: next_rd_data = array_data_i;
        RM_IDENT: next_rd_data = id_word(rd_addr_i);
        RM_QUERY: next_rd_data = query_data_i;
        RM_STATUS: next_rd_data = {{(DATA_W-8){1'b0}}, status_i};
        default: next_rd_data = '0;
      endcase
    end
  end

  // Registered answer, one cycle after the read strobe.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_data_o <= next_rd_data;
      rd_valid_o <= rd_stb_i;
    end
  end

endmodule

//--- test/fcd_host_model.sv
/*
  Behavioural host memory controller for the flash command decoder: issues
  single bus writes and reads and stands in for the array, query table and
  protection storage.
  Assumes the decoder takes a write or read at the edge after it is driven.
*/
`timescale 1ns/1ps
module fcd_host_model
  import fcd_pkg::*;
#(
  parameter int BLK_OFS_W = 14
) (
  input wire logic clk_i,
  output fcd_wr_t host_wr_o,
  output logic rd_stb_o,
  output logic [ADDR_W-1:0] read_location_o,
  output logic [DATA_W-1:0] array_data_o,
  output logic [DATA_W-1:0] query_data_o,
  output logic prot_state_o,
  input wire fcd_op_t op_i,
  input wire logic [DATA_W-1:0] rd_data_i,
  input wire logic rd_valid_i
);
  // The bus is idle at time zero.
  initial begin
    host_wr_o = '0;
    rd_stb_o = 1'b0;
    read_location_o = '0;
  end

  // Stored data is a pattern of the address, so every read can be predicted.
  assign array_data_o = {11'h2aa, read_location_o};
  assign query_data_o = {11'h155, read_location_o};
  assign prot_state_o = read_location_o[BLK_OFS_W]; // Odd blocks are protected.

  // One write; released lines show the inverse so stale values never match.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    output fcd_op_t op);
    @(posedge clk_i);
    host_wr_o <= '{1'b1, a, d};
    @(posedge clk_i);
    host_wr_o <= '{1'b0, ~a, ~d};
    // Sampled mid-cycle, while the one-cycle op pulse stands.
    @(negedge clk_i);
    op = op_i;
    @(posedge clk_i);
  endtask

  // One read; the answer is taken at the edge where valid is seen.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic v);
    @(posedge clk_i);
    rd_stb_o <= 1'b1;
    read_location_o <= a;
    @(posedge clk_i);
    rd_stb_o <= 1'b0;
    read_location_o <= ~a;
    // Sampled mid-cycle, while the valid pulse stands.
    @(negedge clk_i);
    v = rd_valid_i;
    d = rd_data_i;
    @(posedge clk_i);
  endtask
endmodule

//--- test/tb_top.sv
/*
  Self-checking testbench of the flash command decoder: command sequences,
  read modes, operation requests and status handling.
  Assumes the host model in fcd_host_model.sv and the design under hdl/.
*/
`timescale 1ns/1ps
module tb_top
  import fcd_pkg::*;
;
  localparam logic [DATA_W-1:0] MAKER = 32'h0000005c; // Arbitrary value.
  localparam logic [DATA_W-1:0] PART = 32'h00004321; // Arbitrary value.
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic busy = 1'b0;
  logic [7:0] sts_set = 8'h00;
  fcd_wr_t host_wr;
  logic rd_stb, prot;
  logic [ADDR_W-1:0] rd_loc;
  logic [DATA_W-1:0] arr_data, qry_data, rd_data, rdat;
  logic rd_valid, rvld;
  fcd_op_t op, op_out;
  fcd_mode_t mode;
  logic [BURST_W-1:0] burst;
  logic [7:0] status;
  int error_cnt = 0;
  int comparisons = 0;

  always #2 clk_sys = ~clk_sys;

  fcd_top #(.MAKER_CODE(MAKER), .PART_CODE(PART), .BLK_OFS_W(14)) u_dut (
    .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .HOST_WR_I(host_wr), .RD_STB_I(rd_stb),
    .READ_LOCATION_I(rd_loc), .ARRAY_DATA_I(arr_data), .QUERY_DATA_I(qry_data),
    .PROT_STATE_I(prot), .PEC_BUSY_I(busy), .STS_SET_I(sts_set), .OP_O(op_out),
    .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .READ_MODE_O(mode),
    .BURST_SETUP_WORD_O(burst), .STATUS_VALUE_O(status));

  fcd_host_model #(.BLK_OFS_W(14)) u_host (
    .clk_i(clk_sys), .host_wr_o(host_wr), .rd_stb_o(rd_stb), .read_location_o(rd_loc),
    .array_data_o(arr_data), .query_data_o(qry_data), .prot_state_o(prot),
    .op_i(op_out), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

  // Compares with case equality so an unknown never passes.
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    u_host.wr(a, d, op);
  endtask

  task automatic r(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    u_host.rd(a, rdat, rvld);
    check("read valid", rvld, 1'b1);
    check("read data", rdat, exp);
  endtask

  task automatic op_is(input fcd_op_kind_t kind);
    check("op kind", {op.valid, op.kind}, {1'b1, kind});
  endtask

  task automatic t_reset();
    check("mode", mode, RM_ARRAY);
    check("op", op_out, 64'h0);
    check("burst word", burst, BURST_RESET);
    check("status", status, 8'h80);
    $display("test reset done");
  endtask

  // Address lines of single-cycle commands are deliberately odd values.
  task automatic t_modes();
    w(21'h1fffff, 32'h000000ff);
    check("mode", mode, RM_ARRAY);
    r(21'h00321, {11'h2aa, 21'h00321});
    r(21'h00322, {11'h2aa, 21'h00322});
    w(21'h0abcde, 32'hffffff90);
    check("mode", mode, RM_IDENT);
    r(21'h00000, MAKER);
    r(21'h00001, PART);
    r(21'h00005, 32'h0);
    r(21'h0c002, 32'h1);
    r(21'h08002, 32'h0);
    w(21'h12345, 32'h00000098);
    check("mode", mode, RM_QUERY);
    r(21'h00010, {11'h155, 21'h00010});
    w(21'h00aa0, 32'h00000070);
    check("mode", mode, RM_STATUS);
    r(21'h00000, 32'h80);
    $display("test modes done");
  endtask

  task automatic t_erase();
    w(ADR_UNLOCK_A, 32'h20);
    check("op valid", op.valid, 1'b0);
    w(21'h14003, 32'hd0);
    op_is(OP_BLK_ERASE);
    check("op addr", op.addr, 21'h14003);
    r(21'h00010, 32'h80);
    w(ADR_UNLOCK_A, 32'h80);
    w(ADR_UNLOCK_B, 32'hd0);
    op_is(OP_ALL_ERASE);
    $display("test erase done");
  endtask

  task automatic t_program();
    w(ADR_UNLOCK_B, 32'h40);
    w(21'h00123, 32'h12345678);
    op_is(OP_PROGRAM);
    check("op word", {op.otp_ok, op.addr, op.data}, {1'b1, 21'h00123, 32'h12345678});
    w(ADR_UNLOCK_B, 32'h10);
    w(21'h00456, 32'hcafe0001);
    op_is(OP_PROGRAM);
    check("otp ok", op.otp_ok, 1'b0);
    w(ADR_UNLOCK_B, 32'h40);
    w(21'h00789, PGM_ABORT_WORD);
    check("op valid", op.valid, 1'b0);
    $display("test program done");
  endtask

  // Largest buffer: eight words, so the count field is seven.
  task automatic t_buffer();
    w(ADR_UNLOCK_B, 32'he8);
    check("mode", mode, RM_STATUS);
    w(21'h08000, 32'h7);
    op_is(OP_BUF_START);
    for (int i = 0; i < 8; i++) begin
      w(21'h08000 + 21'(i), 32'h11110000 + i);
      op_is(OP_BUF_WORD);
      check("buffer data", op.data, 32'h11110000 + i);
    end
    w(21'h00001, 32'hd0);
    op_is(OP_BUF_COMMIT);
    $display("test buffer done");
  endtask

  task automatic t_config();
    w(21'h00000, 32'h60);
    w(21'h1abcd, 32'h03);
    check("op valid", op.valid, 1'b0);
    check("burst word", burst, 16'habcd);
    r(21'h00004, 32'h80);
    w(21'h00000, 32'h90);
    r(ID_BURST_ADR, 32'h0000abcd);
    w(21'h00000, 32'h60);
    w(21'h0c010, 32'h01);
    op_is(OP_PROT_SET);
    check("op addr", op.addr, 21'h0c010);
    w(21'h00000, 32'h60);
    w(21'h0c010, 32'hd0);
    op_is(OP_PROT_CLR);
    $display("test config done");
  endtask

  // While the engine runs only status reads and suspend get through.
  task automatic t_busy();
    w(ADR_UNLOCK_A, 32'h20);
    w(21'h04000, 32'hd0);
    busy <= 1'b1;
    w(21'h00000, 32'h90);
    check("op valid", op.valid, 1'b0);
    check("mode", mode, RM_STATUS);
    check("ready bit", status[STS_READY_BIT], 1'b0);
    w(ADR_UNLOCK_A, 32'h20);
    w(21'h00000, 32'hb0);
    op_is(OP_SUSPEND);
    busy <= 1'b0;
    w(21'h00000, 32'hd0);
    op_is(OP_RESUME);
    // An erase of all main blocks must refuse a suspend.
    w(ADR_UNLOCK_A, 32'h80);
    w(ADR_UNLOCK_B, 32'hd0);
    op_is(OP_ALL_ERASE);
    busy <= 1'b1;
    w(21'h00000, 32'hb0);
    check("op valid", op.valid, 1'b0);
    busy <= 1'b0;
    $display("test busy done");
  endtask

  // Clear must leave bit 6 and the read mode alone.
  task automatic t_status();
    w(ADR_UNLOCK_A, 32'h20);
    w(21'h00055, 32'h40);
    check("status", status, 8'hb0);
    @(posedge clk_sys);
    sts_set <= 8'h4a;
    @(posedge clk_sys);
    sts_set <= 8'h00;
    w(21'h00000, 32'h90);
    check("status", status, 8'hfa);
    w(21'h1f000, 32'h50);
    check("mode", mode, RM_IDENT);
    check("status", status, 8'hc0);
    // A count of eight, which means nine words, does not fit and is a sequence error.
    w(ADR_UNLOCK_B, 32'he8);
    w(21'h08000, 32'h8);
    check("op valid", op.valid, 1'b0);
    check("status", status, 8'hf0);
    $display("test status done");
  endtask

  task automatic t_otp();
    w(ADR_UNLOCK_B, 32'h49);
    w(ADR_OTP_LOCK, 32'h00);
    op_is(OP_OTP_LOCK);
    $display("test otp done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence after eight cycles of reset.
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_modes();
    t_erase();
    t_program();
    t_buffer();
    t_config();
    t_busy();
    t_status();
    t_otp();
    finish_test();
  end

  // The run needs well under two thousand cycles; this is five thousand.
  initial begin
    #20000;
    error_cnt++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
